// File: counter_stamp_postprocessor.sv
// top: turns start/stop sample records into stamps and results
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module counter_stamp_postprocessor
  import cs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rec_valid_i,
  output logic rec_ready_o,
  input wire logic [EVT_W-1:0] rec_event_i,
  input wire logic [EVT_W-1:0] rec_time_i,
  input wire logic [INT_W-1:0] rec_interp_i,
  input wire logic rec_group_begin_i,
  input wire logic rec_suppressed_i
);
  // =====================================
  // declarations
  logic [31:0] ctrl_r, ctrl_nxt, evc_r, evc_nxt, tmc_r, tmc_nxt;
  logic [31:0] off_r, off_nxt, tmax_r, tmax_nxt, dat_r, dat_nxt;
  logic ack_r, ack_nxt, wr;
  phase_t phase_r, phase_nxt;
  logic s1_v_r, s1_stop_r, s1_grp_r, s1_supp_r;
  logic [INT_W-1:0] s1_int_r;
  logic acc, variant, clr_mode, at_start, s1_start, s1_end, div_go;
  logic [STAMP_W-1:0] ev_fix, tm_fix, ev_sc, st_t, sp_t, st_st, sp_st;
  logic [STAMP_W-1:0] gate, evt_el, corr48, off48, raw_stamp;
  logic signed [STAMP_W-1:0] dif, lim;
  logic [STAMP_W-1:0] st_tm_r, st_tm_nxt, st_evt_r, st_evt_nxt;
  logic [INT_W-1:0] st_int_r, st_int_nxt;
  logic st_supp_r, st_supp_nxt;
  logic [STAMP_W-1:0] ti_r, ti_nxt, st_stamp_r, st_stamp_nxt, sp_stamp_r, sp_stamp_nxt;
  logic [31:0] el_r, el_nxt, miss_r, miss_nxt, pstop_r, pstop_nxt;
  logic [31:0] freq_r, freq_nxt, per_r, per_nxt;
  logic pok_r, pok_nxt, new_r, new_nxt, supp_r, supp_nxt, mok_r, mok_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic res_set, miss_set, st_clr;
  logic f_busy, p_busy, f_done;
  logic [DIV_W-1:0] f_quot, p_quot;

  // byte-lane merge, shared by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // =====================================
  // record intake
  // stall while the dividers run so a result is never overwritten
  assign rec_ready_o = ctrl_r[CTRL_EN] && !f_busy && !p_busy;
  assign acc = rec_valid_i && rec_ready_o;
  assign variant = ctrl_r[CTRL_LAYOUT];
  // variant always counts from a cleared counter
  assign clr_mode = ctrl_r[CTRL_CLR] || variant;
  assign at_start = (phase_r == PH_START);
  assign s1_start = s1_v_r && !s1_stop_r;
  assign s1_end = s1_v_r && s1_stop_r;
  assign div_go = s1_end;

  always_comb begin
    phase_nxt = phase_r;
    if (!ctrl_r[CTRL_EN]) begin
      phase_nxt = PH_START;
    end else if (acc) begin
      phase_nxt = at_start ? PH_STOP : PH_START;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_r <= PH_START;
      s1_v_r <= 1'b0;
      s1_stop_r <= 1'b0;
      s1_grp_r <= 1'b0;
      s1_supp_r <= 1'b0;
      s1_int_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      s1_v_r <= acc;
      s1_stop_r <= !at_start;
      s1_grp_r <= rec_group_begin_i;
      s1_supp_r <= rec_suppressed_i;
      s1_int_r <= rec_interp_i;
    end
  end

  cs_unwrap u_evt (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sample_i(acc),
    .raw_i(rec_event_i),
    .cmp_en_i(!(clr_mode && at_start)),
    .clear_i(clr_mode && at_start),
    .corr_i(evc_r),
    .fixed_o(ev_fix)
  );

  cs_unwrap u_time (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sample_i(acc),
    .raw_i(rec_time_i),
    .cmp_en_i(!variant),
    .clear_i(1'b0),
    .corr_i(tmc_r),
    .fixed_o(tm_fix)
  );

  // =====================================
  // stamp arithmetic, valid while s1_v_r is high
  always_comb begin
    corr48 = {16'h0, tmc_r};
    off48 = {{16{off_r[31]}}, off_r};
    // third channel counts one in four
    ev_sc = ctrl_r[CTRL_CHANC] ? {ev_fix[STAMP_W-3:0], 2'b00} : ev_fix;
    st_t = st_tm_r;
    sp_t = tm_fix;
    dif = $signed(tm_fix - st_tm_r);
    lim = $signed({16'h0, tmax_r});
    if (variant && (dif > lim)) begin
      st_t = st_tm_r + corr48;
    end
    if (variant && (dif < -lim)) begin
      sp_t = tm_fix + corr48;
    end
    // 2 ns count minus 0.1 ns interpolator
    st_st = st_t * TIME_LSB_TENTHS - {40'h0, st_int_r} * INT_LSB_TENTHS;
    raw_stamp = sp_t * TIME_LSB_TENTHS - {40'h0, s1_int_r} * INT_LSB_TENTHS;
    // offset on the stop side only
    sp_st = raw_stamp + off48;
    // gate time is the same span
    gate = sp_st - st_st;
    evt_el = ev_sc - st_evt_r;
  end

  // =====================================
  // result registers
  always_comb begin
    st_tm_nxt = st_tm_r;
    st_int_nxt = st_int_r;
    st_evt_nxt = st_evt_r;
    st_supp_nxt = st_supp_r;
    ti_nxt = ti_r;
    st_stamp_nxt = st_stamp_r;
    sp_stamp_nxt = sp_stamp_r;
    el_nxt = el_r;
    miss_nxt = miss_r;
    pstop_nxt = pstop_r;
    pok_nxt = pok_r;
    supp_nxt = supp_r;
    cnt_nxt = cnt_r;
    res_set = 1'b0;
    miss_set = 1'b0;
    freq_nxt = f_done ? f_quot[31:0] : freq_r;
    per_nxt = f_done ? p_quot[31:0] : per_r;
    if (s1_start) begin
      st_tm_nxt = tm_fix;
      st_int_nxt = s1_int_r;
      st_evt_nxt = ev_sc;
      st_supp_nxt = s1_supp_r;
      if (s1_grp_r) begin
        pok_nxt = 1'b0;
      end
      // gap from last stop to this start
      if (!variant && pok_r && !s1_grp_r) begin
        miss_nxt = ev_sc[31:0] - pstop_r - 32'h1;
        miss_set = 1'b1;
      end
    end
    if (s1_end) begin
      st_stamp_nxt = st_st;
      sp_stamp_nxt = sp_st;
      ti_nxt = gate;
      el_nxt = evt_el[31:0];
      pstop_nxt = ev_sc[31:0];
      pok_nxt = 1'b1;
      res_set = 1'b1;
      supp_nxt = st_supp_r || s1_supp_r;
      cnt_nxt = cnt_r + 8'h1;
      if (variant) begin
        miss_nxt = evt_el[31:0] - 32'h1;
        miss_set = 1'b1;
      end
    end
    // set wins over a software clear in the same cycle
    new_nxt = res_set || (new_r && !st_clr);
    mok_nxt = miss_set || (mok_r && !st_clr);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_tm_r <= '0;
      st_int_r <= '0;
      st_evt_r <= '0;
      st_supp_r <= 1'b0;
      ti_r <= '0;
      st_stamp_r <= '0;
      sp_stamp_r <= '0;
      el_r <= '0;
      miss_r <= '0;
      pstop_r <= '0;
      pok_r <= 1'b0;
      supp_r <= 1'b0;
      cnt_r <= '0;
      new_r <= 1'b0;
      mok_r <= 1'b0;
      freq_r <= '0;
      per_r <= '0;
    end else begin
      st_tm_r <= st_tm_nxt;
      st_int_r <= st_int_nxt;
      st_evt_r <= st_evt_nxt;
      st_supp_r <= st_supp_nxt;
      ti_r <= ti_nxt;
      st_stamp_r <= st_stamp_nxt;
      sp_stamp_r <= sp_stamp_nxt;
      el_r <= el_nxt;
      miss_r <= miss_nxt;
      pstop_r <= pstop_nxt;
      pok_r <= pok_nxt;
      supp_r <= supp_nxt;
      cnt_r <= cnt_nxt;
      new_r <= new_nxt;
      mok_r <= mok_nxt;
      freq_r <= freq_nxt;
      per_r <= per_nxt;
    end
  end

  // events over time, time over events
  // limitation: frequency dividend wraps above 2^64 / 1e10 events
  cs_div u_freq (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(div_go),
    .dividend_i({32'h0, evt_el[31:0]} * TENTHS_PER_S),
    .divisor_i({16'h0, gate}),
    .busy_o(f_busy),
    .done_o(f_done),
    .quot_o(f_quot)
  );

  cs_div u_per (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(div_go),
    .dividend_i({16'h0, gate}),
    .divisor_i({32'h0, evt_el[31:0]}),
    .busy_o(p_busy),
    .done_o(),
    .quot_o(p_quot)
  );

  // =====================================
  // wishbone slave, one wait state, unmapped reads zero
  // write lands on the edge where the master sees ack, never earlier
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign st_clr = wr && (wb_adr_i == ADR_STATUS) && wb_sel_i[0] && wb_dat_i[ST_NEW];

  always_comb begin
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    ctrl_nxt = ctrl_r;
    evc_nxt = evc_r;
    tmc_nxt = tmc_r;
    off_nxt = off_r;
    tmax_nxt = tmax_r;
    if (wr) begin
      unique case (wb_adr_i)
        ADR_CTRL: ctrl_nxt = merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'hF;
        ADR_EVT_CORR: evc_nxt = merge(evc_r, wb_dat_i, wb_sel_i);
        ADR_TIME_CORR: tmc_nxt = merge(tmc_r, wb_dat_i, wb_sel_i);
        ADR_OFFSET: off_nxt = merge(off_r, wb_dat_i, wb_sel_i);
        ADR_TMAX: tmax_nxt = merge(tmax_r, wb_dat_i, wb_sel_i);
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    unique case (wb_adr_i)
      ADR_CTRL: dat_nxt = ctrl_r;
      ADR_EVT_CORR: dat_nxt = evc_r;
      ADR_TIME_CORR: dat_nxt = tmc_r;
      ADR_OFFSET: dat_nxt = off_r;
      ADR_TMAX: dat_nxt = tmax_r;
      ADR_STATUS: dat_nxt = {16'h0, cnt_r, 4'h0, mok_r, f_busy, supp_r, new_r};
      ADR_TI_LO: dat_nxt = ti_r[31:0];
      ADR_TI_HI: dat_nxt = {16'h0, ti_r[47:32]};
      ADR_EVT_EL: dat_nxt = el_r;
      ADR_MISSED: dat_nxt = miss_r;
      ADR_FREQ: dat_nxt = freq_r;
      ADR_PERIOD: dat_nxt = per_r;
      default: dat_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
      ctrl_r <= CTRL_RST;
      evc_r <= CORR_RST;
      tmc_r <= CORR_RST;
      off_r <= CORR_RST;
      tmax_r <= TMAX_RST;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      evc_r <= evc_nxt;
      tmc_r <= tmc_nxt;
      off_r <= off_nxt;
      tmax_r <= tmax_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // =====================================
  // checks
  sequence s_stop;
    s1_v_r && s1_stop_r;
  endsequence

  property p_stall;
    @(posedge clk_i) disable iff (!rst_b_i)
    (f_busy || p_busy) |-> !rec_ready_o;
  endproperty
  a_stall: assert property (p_stall) else $error("record taken while dividing");

  property p_interval;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_stop |=> ti_r == sp_stamp_r - st_stamp_r;
  endproperty
  a_interval: assert property (p_interval) else $error("interval mismatch");

  property p_stop_offset;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_stop |=> sp_stamp_r == $past(raw_stamp) + {{16{$past(off_r[31])}}, $past(off_r)};
  endproperty
  a_stop_offset: assert property (p_stop_offset) else $error("stop offset missing");

  property p_miss_pair;
    @(posedge clk_i) disable iff (!rst_b_i)
    s1_start && !variant && pok_r && !s1_grp_r
      |=> mok_r && miss_r == $past(ev_sc[31:0]) - $past(pstop_r) - 32'h1;
  endproperty
  a_miss_pair: assert property (p_miss_pair) else $error("paired missed count");

  property p_miss_inside;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_stop ##0 variant |=> miss_r == el_r - 32'h1;
  endproperty
  a_miss_inside: assert property (p_miss_inside) else $error("inside missed count");

  property p_chanc;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_stop ##0 ctrl_r[CTRL_CHANC] |=> el_r[1:0] == 2'b00;
  endproperty
  a_chanc: assert property (p_chanc) else $error("third channel not scaled");

  property p_result_flag;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_stop |=> new_r && cnt_r == $past(cnt_r) + 8'h1 ##1 (f_busy && p_busy);
  endproperty
  a_result_flag: assert property (p_result_flag) else $error("result not flagged");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (!rst_b_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
endmodule
`default_nettype wire

// File: cs_pkg.sv
// package: constants and types for the counter stamp postprocessor
package cs_pkg;
  localparam int EVT_W = 32;
  localparam int STAMP_W = 48;
  localparam int DIV_W = 64;
  localparam int INT_W = 8;
  // stamps are kept in units of 0.1 ns
  localparam logic [STAMP_W-1:0] TIME_LSB_TENTHS = 48'h14;
  localparam logic [STAMP_W-1:0] INT_LSB_TENTHS = 48'h1;
  localparam logic [DIV_W-1:0] TENTHS_PER_S = 64'h2540BE400;
  localparam logic [6:0] DIV_LAST = 7'h3F;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_EVT_CORR = 8'h04;
  localparam logic [7:0] ADR_TIME_CORR = 8'h08;
  localparam logic [7:0] ADR_OFFSET = 8'h0C;
  localparam logic [7:0] ADR_TMAX = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_TI_LO = 8'h18;
  localparam logic [7:0] ADR_TI_HI = 8'h1C;
  localparam logic [7:0] ADR_EVT_EL = 8'h20;
  localparam logic [7:0] ADR_MISSED = 8'h24;
  localparam logic [7:0] ADR_FREQ = 8'h28;
  localparam logic [7:0] ADR_PERIOD = 8'h2C;
  localparam int CTRL_EN = 0;
  localparam int CTRL_LAYOUT = 1;
  localparam int CTRL_CHANC = 2;
  localparam int CTRL_CLR = 3;
  localparam int ST_NEW = 0;
  localparam int ST_SUPP = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_MISS = 3;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [31:0] CORR_RST = 32'h0;
  localparam logic [31:0] TMAX_RST = 32'h7FFFFFFF;
  typedef enum logic {PH_START = 1'b0, PH_STOP = 1'b1} phase_t;
  typedef enum logic {DV_IDLE = 1'b0, DV_RUN = 1'b1} div_state_t;
endpackage

// File: cs_unwrap.sv
// module: rollover corrector with a running cumulative offset
`timescale 1ns/1ns
`default_nettype none
module cs_unwrap
  import cs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sample_i,
  input wire logic [EVT_W-1:0] raw_i,
  input wire logic cmp_en_i,
  input wire logic clear_i,
  input wire logic [EVT_W-1:0] corr_i,
  output logic [STAMP_W-1:0] fixed_o
);
  logic [EVT_W-1:0] prev_r, prev_nxt;
  logic [STAMP_W-1:0] offs_r, offs_nxt, fixed_r, fixed_nxt, base;

  // =====================================
  // scan: compare with predecessor, step offset
  always_comb begin
    base = '0;
    prev_nxt = prev_r;
    offs_nxt = offs_r;
    fixed_nxt = fixed_r;
    if (sample_i) begin
      base = clear_i ? '0 : offs_r;
      if (cmp_en_i && (raw_i < prev_r)) begin
        base = base + {16'h0, corr_i};
      end
      offs_nxt = base;
      prev_nxt = raw_i;
      fixed_nxt = {16'h0, raw_i} + base;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_r <= '0;
      offs_r <= '0;
      fixed_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      offs_r <= offs_nxt;
      fixed_r <= fixed_nxt;
    end
  end

  assign fixed_o = fixed_r;

  property p_wrap_step;
    @(posedge clk_i) disable iff (!rst_b_i)
    sample_i && cmp_en_i && !clear_i && (raw_i < prev_r)
      |=> offs_r == $past(offs_r) + {16'h0, $past(corr_i)};
  endproperty
  a_wrap_step: assert property (p_wrap_step) else $error("wrap step missing");

  property p_fixed_sum;
    @(posedge clk_i) disable iff (!rst_b_i)
    sample_i |=> fixed_o == {16'h0, $past(raw_i)} + offs_r;
  endproperty
  a_fixed_sum: assert property (p_fixed_sum) else $error("offset not applied");
endmodule
`default_nettype wire

// File: cs_div.sv
// module: serial restoring divider, one quotient bit per clock
`timescale 1ns/1ns
`default_nettype none
module cs_div
  import cs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [DIV_W-1:0] dividend_i,
  input wire logic [DIV_W-1:0] divisor_i,
  output logic busy_o,
  output logic done_o,
  output logic [DIV_W-1:0] quot_o
);
  div_state_t state_r, state_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic [DIV_W:0] rem_r, rem_nxt, trial;
  logic [DIV_W-1:0] quo_r, quo_nxt, dsr_r, dsr_nxt;
  logic done_r, done_nxt;

  // =====================================
  // divide: zero divisor yields all ones
  always_comb begin
    trial = {rem_r[DIV_W-1:0], quo_r[DIV_W-1]};
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    dsr_nxt = dsr_r;
    done_nxt = 1'b0;
    unique case (state_r)
      DV_IDLE: begin
        if (start_i) begin
          state_nxt = DV_RUN;
          quo_nxt = dividend_i;
          dsr_nxt = divisor_i;
          rem_nxt = '0;
          cnt_nxt = DIV_LAST;
        end
      end
      DV_RUN: begin
        if (trial >= {1'b0, dsr_r}) begin
          rem_nxt = trial - {1'b0, dsr_r};
          quo_nxt = {quo_r[DIV_W-2:0], 1'b1};
        end else begin
          rem_nxt = trial;
          quo_nxt = {quo_r[DIV_W-2:0], 1'b0};
        end
        if (cnt_r == 7'h0) begin
          state_nxt = DV_IDLE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 7'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= DV_IDLE;
      cnt_r <= '0;
      rem_r <= '0;
      quo_r <= '0;
      dsr_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      dsr_r <= dsr_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_o = (state_r == DV_RUN);
  assign done_o = done_r;
  assign quot_o = quo_r;

  sequence s_run;
    busy_o [*8];
  endsequence
  property p_latency;
    @(posedge clk_i) disable iff (!rst_b_i)
    start_i && !busy_o |=> s_run ##57 done_o;
  endproperty
  a_latency: assert property (p_latency) else $error("quotient late");

  property p_done_pulse;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_o |=> !done_o && !busy_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
endmodule
`default_nettype wire

// File: meas_device_model.sv
// device model: emits start and stop sample records over the record handshake
`timescale 1ns/1ns
`default_nettype none
module meas_device_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic chc_i,
  input wire logic clr_i,
  output logic valid_o,
  output logic [31:0] event_o,
  output logic [31:0] time_o,
  output logic [7:0] interp_o,
  output logic gb_o,
  output logic sup_o
);
  // ========
  // record driver
  initial begin
    valid_o = 1'b0;
    {event_o, time_o, interp_o, gb_o, sup_o} = '0;
  end
  task automatic put(input logic [31:0] e, t, input logic [7:0] n, input logic g, s);
    @(posedge clk_i);
    valid_o <= 1'b1;
    {event_o, time_o, interp_o, gb_o, sup_o} <= {e, t, n, g, s};
    do @(posedge clk_i); while (ready_i !== 1'b1);
    // released lines flip, so stale data never passes for a record
    valid_o <= 1'b0;
    {event_o, time_o, interp_o, gb_o, sup_o} <= ~{e, t, n, g, s};
  endtask
  task automatic send_meas(input logic [31:0] b, es, ee, ts, te, input logic [7:0] is, ie,
                           input logic g, s);
    logic [31:0] c;
    c = clr_i ? b : 32'h0;
    put(chc_i ? (es - c) >> 2 : es - c, ts, is, g, 1'b0);
    put(chc_i ? (ee - c) >> 2 : ee - c, te, ie, 1'b0, s);
  endtask
endmodule
`default_nettype wire

// File: counter_stamp_postprocessor_bench.sv
// bench: drives the postprocessor from a device model and checks its registers
`timescale 1ns/1ns
`default_nettype none
module counter_stamp_postprocessor_bench
  import cs_pkg::*;
;
  logic clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rec_valid_i, rec_ready_o;
  logic rec_group_begin_i, rec_suppressed_i, chc, clrm, vl, hv;
  logic [7:0] wb_adr_i, rec_interp_i, cnt;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rec_event_i, rec_time_i, pe, pt, ec, tc, off, tmax;
  logic [47:0] oe, ot, pstop;
  logic [63:0] expq[$];
  logic [63:0] x;
  int err_total = 0, n_tests = 0, cyc_n = 0, r;
  // ========
  // design, device model, clock
  counter_stamp_postprocessor uut (.clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rec_valid_i, .rec_ready_o,
    .rec_event_i, .rec_time_i, .rec_interp_i, .rec_group_begin_i, .rec_suppressed_i);
  meas_device_model dev (.clk_i(clk_i), .ready_i(rec_ready_o), .chc_i(chc), .clr_i(clrm),
    .valid_o(rec_valid_i), .event_o(rec_event_i), .time_o(rec_time_i),
    .interp_o(rec_interp_i), .gb_o(rec_group_begin_i), .sup_o(rec_suppressed_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ========
  // reporting
  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, g, m);
    n_tests++;
    if ((g & m) !== (e & m)) begin
      err_total++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask
  // read data is judged against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (expq.size() == 0) err_total++;
      else begin
        x = expq.pop_front();
        cmp(x[31:0], wb_dat_o, x[63:32]);
      end
    end
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 6000) begin
      err_total++;
      print_verdict;
    end
  end
  // ========
  // bus cycles and setup
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    expq.push_back({m, e});
    wb(1'b0, a, 32'h0);
  endtask
  task automatic rst;
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    {hv, cnt, oe, ot, pe, pt} = '0;
  endtask
  task automatic cfg(input logic [3:0] c);
    chc = c[CTRL_CHANC];
    vl = c[CTRL_LAYOUT];
    clrm = c[CTRL_CLR] | c[CTRL_LAYOUT];
    wb(1'b1, ADR_EVT_CORR, ec);
    wb(1'b1, ADR_TIME_CORR, tc);
    wb(1'b1, ADR_OFFSET, off);
    wb(1'b1, ADR_TMAX, tmax);
    wb(1'b1, ADR_CTRL, {28'h0, c});
  endtask
  // ========
  // reference of the consumer arithmetic
  function automatic logic [31:0] rep(input logic [31:0] v, b);
    return chc ? (v - b) >> 2 : v - b;
  endfunction
  task automatic unw(input logic [31:0] v, c, input logic k, inout logic [47:0] o,
                     inout logic [31:0] p, output logic [47:0] f);
    if (k && v < p) o = o + {16'h0, c};
    p = v;
    f = {16'h0, v} + o;
  endtask
  task automatic meas(input logic [31:0] b, es, ee, ts, te, input logic s);
    logic [7:0] is, ie;
    logic [47:0] cs, ce, xs, xe, ti, el, k;
    logic [63:0] q;
    is = 8'($urandom_range(99));
    ie = 8'($urandom_range(99));
    if (clrm) oe = '0;
    unw(rep(es, clrm ? b : 32'h0), ec, hv && !clrm, oe, pe, cs);
    unw(rep(ee, clrm ? b : 32'h0), ec, 1'b1, oe, pe, ce);
    if (vl) begin
      xs = {16'h0, ts};
      xe = {16'h0, te};
      if ($signed(te - ts) > $signed(tmax)) xs = xs + {16'h0, tc};
      else if ($signed(te - ts) < -$signed(tmax)) xe = xe + {16'h0, tc};
    end else begin
      unw(ts, tc, hv, ot, pt, xs);
      unw(te, tc, 1'b1, ot, pt, xe);
    end
    k = chc ? 48'h4 : 48'h1;
    ti = xe * TIME_LSB_TENTHS - {40'h0, ie} + {{16{off[31]}}, off};
    ti = ti - (xs * TIME_LSB_TENTHS - {40'h0, is});
    el = (ce - cs) * k;
    dev.send_meas(b, es, ee, ts, te, is, ie, !hv, s);
    repeat (3) @(posedge clk_i);
    rd(ADR_STATUS, 32'h4, 32'h4); // dividers still busy
    repeat (70) @(posedge clk_i);
    cnt = cnt + 8'h1;
    rd(ADR_TI_LO, ti[31:0], '1); // interval low
    rd(ADR_TI_HI, {16'h0, ti[47:32]}, 32'hFFFF); // interval high
    rd(ADR_EVT_EL, el[31:0], '1); // elapsed events
    rd(ADR_STATUS, {16'h0, cnt, 6'h0, s, 1'b1}, 32'hFF03); // status flags
    if (vl) rd(ADR_MISSED, el[31:0] - 32'h1, '1); // missed inside
    else begin
      if (hv && !clrm) rd(ADR_MISSED, 32'(cs * k - pstop - 48'h1), '1); // missed between
      q = ({16'h0, el} * TENTHS_PER_S) / {16'h0, ti};
      rd(ADR_FREQ, q[31:0], '1); // frequency over gate
      q = {16'h0, ti} / {16'h0, el};
      rd(ADR_PERIOD, q[31:0], '1); // period
    end
    wb(1'b1, ADR_STATUS, 32'h1);
    pstop = ce * k;
    hv = 1'b1;
  endtask
  // ========
  // main sequence
  initial begin
    {rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, chc, clrm, vl} = '0;
    wb_sel_i = 4'hF;
    ec = 32'h00010000;
    tc = 32'hFFFFFFFF;
    off = 32'hFFFFFFF6;
    tmax = 32'h00000064;
    void'($urandom(32'hB63FF8AA));
    rst;
    // reset values, unmapped place, upper control bits
    rd(ADR_CTRL, CTRL_RST, '1);
    rd(ADR_TMAX, TMAX_RST, '1);
    rd(ADR_TIME_CORR, CORR_RST, '1);
    rd(ADR_STATUS, 32'h0, 32'hFF0F);
    wb(1'b1, 8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0, '1);
    wb(1'b1, ADR_CTRL, 32'hFFFFFFF0);
    rd(ADR_CTRL, 32'h0, '1);
    // paired layout, wraps between and inside measurements
    cfg(4'h1);
    r = $urandom_range(500);
    meas(0, 100 + r, 2200 + r, 1000, 6000 + r, 1'b0); // plain pair
    meas(0, 5, 900, 32'hFFFFF000, 32'h800, 1'b0); // both wraps
    meas(0, 1000, 4000, 32'h10000, 32'h30000, 1'b1); // suppressed stop
    // third channel, event counter cleared before start
    rst;
    cfg(4'hD);
    meas(1000, 5000, 1040, 100, 3000, 1'b0); // stop wrap
    meas(2000, 2008, 2400, 4000, 9000, 1'b0); // start not compared
    // variant layout with the in-pair limit
    rst;
    cfg(4'h3);
    meas(0, 10, 60, 1000, 1500, 1'b0); // start corrected
    meas(0, 20, 300, 3000, 2500, 1'b0); // stop corrected
    meas(0, 7, 80 + r, 5000, 5050, 1'b0); // within limit
    repeat (5) @(posedge clk_i);
    if (expq.size() != 0) err_total++;
    print_verdict;
  end
endmodule
`default_nettype wire
